// ### hw/ecr_pkg.sv
// package for the extended control register block: offsets, fields, modes, timing.
// assumes a byte-wide host i/o port already decoded to the parallel port base.
package ecr_pkg;
  localparam logic [10:0] OFS_FIFO = 11'h400; // fifo / capability a
  localparam logic [10:0] OFS_CAPB = 11'h401; // capability b
  localparam logic [10:0] OFS_ECR = 11'h402; // extended control register
  localparam int MODE_HI = 7; // mode field top bit
  localparam int MODE_LO = 5; // mode field low bit
  localparam int BIT_FAULT_DIS = 4; // fault interrupt disable
  localparam int BIT_DMA_EN = 3; // dma enable
  localparam int BIT_SVC_MASK = 2; // service interrupt mask
  localparam int BIT_FULL = 1; // fifo full
  localparam int BIT_EMPTY = 0; // fifo empty
  localparam logic [2:0] ECR_CTRL_RESET = 3'h1; // fault enabled, service masked, dma off
  localparam logic [7:0] CAPB_READ_VAL = 8'h00; // capability b value, no compression
  localparam logic [7:0] CAPA_READ_VAL = 8'h10; // capability a: byte-wide port
  localparam int CLK_HZ = 20_000_000; // system clock rate
  localparam int IRQ_PULSE_NS = 500; // low pulse width on the interrupt line
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000; // rounded up
  localparam int FIFO_DEPTH = 16; // fifo words
  typedef enum logic [2:0] {
    MODE_STD, MODE_BIDIR, MODE_FIFO, MODE_ECP, MODE_EPP, MODE_RSVD, MODE_TEST, MODE_CFG
  } port_mode_e;
  typedef struct packed {
    logic [10:0] addr; // offset from port base
    logic [7:0] wdata; // write data
    logic wr; // one-cycle write strobe
    logic rd; // one-cycle read strobe
  } host_req_s;
  typedef struct packed {
    logic strobe_oe; // control line output enables
    logic push_pull; // 1: push-pull, 0: open collector
    logic data_oe; // data line output enable
  } drive_s;
endpackage : ecr_pkg

// ### hw/byte_fifo.sv
// byte fifo with valid/ready on both sides and a flush input.
// assumes a single clock and synchronous flush.
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // synchronised reset, active low
  input wire logic i_flush, // empties the fifo
  input wire logic i_in_valid, // write side valid
  output logic o_in_ready, // write side ready (not full)
  input wire logic [WIDTH-1:0] i_in_data, // write data
  output logic o_out_valid, // read side valid (not empty)
  input wire logic i_out_ready, // read side ready
  output logic [WIDTH-1:0] o_out_data, // head data
  output logic [$clog2(DEPTH):0] o_count // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage array
  logic [AW-1:0] wp_r; // write pointer
  logic [AW-1:0] rp_r; // read pointer
  logic [AW:0] cnt_r; // fill count
  logic push; // accepted write
  logic pop; // accepted read
  assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = i_out_ready & o_out_valid;
  assign o_out_data = mem[rp_r];
  assign o_count = cnt_r;
  // storage has no reset: contents are only read when counted valid
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= i_in_data;
    end
  end
  // pointers and count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (i_flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : byte_fifo
`default_nettype wire

// ### hw/ecp_extended_control.sv
// extended control register of the parallel port with its fifo, mode decode,
// service/fault interrupt generation and dma request gating.
// assumes host strobes are one-cycle pulses synchronous to i_clk, already qualified by base decode.
`timescale 1ns/100ps
`default_nettype none
module ecp_extended_control
  import ecr_pkg::*;
#(
  parameter int DEPTH = ecr_pkg::FIFO_DEPTH, // fifo depth
  parameter int WR_THRESH = 8, // write_free_threshold
  parameter int RD_THRESH = 8 // read_fill_threshold
) (
  input wire logic i_clk, // 20 mhz system clock
  input wire logic i_reset_n, // async reset, active low
  input wire ecr_pkg::host_req_s i_req, // host i/o request
  output logic [7:0] o_rdata, // read data, registered
  input wire logic i_direction, // direction bit from device control register
  input wire logic i_epp_option_config, // epp support option
  input wire logic i_peripheral_fault_n, // peripheral fault input, active low
  input wire logic i_dma_ack, // dma acknowledge, moves one byte
  input wire logic i_dma_tc, // dma terminal count pulse
  input wire logic [7:0] i_dma_wdata, // dma byte into fifo
  input wire logic [7:0] i_port_rdata, // byte received from the peripheral
  input wire logic i_port_rvalid, // received byte valid
  output logic o_port_rready, // fifo can take a received byte
  output logic [7:0] o_port_wdata, // fifo head for transmit
  output logic o_port_wvalid, // transmit byte available
  input wire logic i_port_wready, // handshake engine takes the head byte
  output logic o_compat_xfer, // compatibility handshake engine enable
  output logic o_ecp_xfer, // ecp handshake engine enable
  output logic o_epp_enable, // epp engine enable
  output ecr_pkg::drive_s o_drive, // pin driver configuration
  output logic o_data_readback_pins, // data port returns pin levels
  output logic o_eff_direction, // effective direction, 1 = input
  output logic o_dma_req, // dma request
  output logic o_irq_out, // interrupt line level when driven
  output logic o_irq_oe // interrupt line output enable
);
  logic [1:0] rst_sync_r; // reset release synchroniser
  logic rst_n; // synchronised reset
  logic [2:0] mode_r; // mode field
  logic fault_dis_r; // fault_irq_disable_n
  logic dma_en_r; // dma_transfer_enable
  logic svc_mask_r; // service_irq_mask
  logic fault_d_r; // previous fault level
  logic [7:0] irq_cnt_r; // pulse length counter
  port_mode_e mode; // typed mode
  logic fifo_modes; // modes using the fifo
  logic wr_ecr; // ecr write
  logic fifo_wr_host; // host writes fifo
  logic fifo_rd_host; // host reads fifo
  logic in_valid; // fifo write valid
  logic [7:0] in_data; // fifo write data
  logic out_ready; // fifo read ready
  logic in_ready; // fifo not full
  logic out_valid; // fifo not empty
  logic [7:0] head; // fifo head
  logic [$clog2(DEPTH):0] count; // fifo fill
  logic [7:0] last_rd_r; // last byte read, reread on underrun
  logic svc_cond; // service condition
  logic svc_irq; // service interrupt event
  logic fault_irq; // fault interrupt event
  logic fault_ecp; // fault logic active
  // release reset through two flops; first flop feeds only the second
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];
  assign mode = port_mode_e'(mode_r);
  assign wr_ecr = i_req.wr && (i_req.addr == OFS_ECR);
  // direction forced to output in standard and compatibility fifo modes
  assign o_eff_direction = (mode == MODE_STD || mode == MODE_FIFO) ? 1'b0 : i_direction;
  // fifo is used by fifo, ecp and test modes; reserved mode stays idle
  assign fifo_modes = (mode == MODE_FIFO) || (mode == MODE_ECP) || (mode == MODE_TEST);
  // mode decode for engines and drivers
  always_comb begin
    o_compat_xfer = (mode == MODE_FIFO);
    o_ecp_xfer = (mode == MODE_ECP);
    o_epp_enable = (mode == MODE_EPP) && i_epp_option_config;
    o_drive.strobe_oe = 1'b1;
    o_drive.push_pull = (mode != MODE_STD);
    o_drive.data_oe = !o_eff_direction;
    o_data_readback_pins = (mode != MODE_STD);
  end
  // fifo write: ecp data and command offsets share one queue in ecp forward
  assign fifo_wr_host = i_req.wr && (i_req.addr == OFS_FIFO || (mode == MODE_ECP && i_req.addr == 11'h000))
                        && fifo_modes && (mode != MODE_CFG);
  assign fifo_rd_host = i_req.rd && (i_req.addr == OFS_FIFO) && fifo_modes;
  // a host write, a dma byte in the forward direction, or a received byte in ecp reverse
  always_comb begin
    in_valid = 1'b0;
    in_data = i_req.wdata;
    o_port_rready = 1'b0;
    if (fifo_wr_host) begin
      in_valid = 1'b1;
    end else if (i_dma_ack && o_dma_req && !o_eff_direction) begin
      in_valid = 1'b1;
      in_data = i_dma_wdata;
    end else if (mode == MODE_ECP && o_eff_direction) begin
      o_port_rready = in_ready;
      in_valid = i_port_rvalid;
      in_data = i_port_rdata;
    end
  end
  // test mode never feeds the port; transmit only in compat or ecp forward
  assign o_port_wvalid = out_valid && !o_eff_direction && (o_compat_xfer || o_ecp_xfer);
  assign o_port_wdata = head;
  assign out_ready = fifo_rd_host || (o_port_wvalid && i_port_wready) ||
                     (i_dma_ack && o_dma_req && o_eff_direction);
  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_flush(!fifo_modes),
    .i_in_valid(in_valid),
    .o_in_ready(in_ready),
    .i_in_data(in_data),
    .o_out_valid(out_valid),
    .i_out_ready(out_ready),
    .o_out_data(head),
    .o_count(count)
  );
  // control fields of the ecr; hardware set of the mask wins over a software clear
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 3'h0;
      {fault_dis_r, dma_en_r, svc_mask_r} <= ECR_CTRL_RESET;
    end else begin
      if (wr_ecr) begin
        mode_r <= i_req.wdata[MODE_HI:MODE_LO];
        fault_dis_r <= i_req.wdata[BIT_FAULT_DIS];
        dma_en_r <= i_req.wdata[BIT_DMA_EN];
        svc_mask_r <= i_req.wdata[BIT_SVC_MASK];
      end
      if (svc_irq) begin
        svc_mask_r <= 1'b1;
      end
    end
  end
  // service condition per case; checked every cycle so clearing the mask fires at once
  always_comb begin
    if (dma_en_r) begin
      svc_cond = i_dma_tc;
    end else if (!o_eff_direction) begin
      svc_cond = fifo_modes && ((DEPTH - int'(count)) >= WR_THRESH);
    end else begin
      svc_cond = fifo_modes && (int'(count) >= RD_THRESH);
    end
  end
  // mask held or being written to one suppresses; writing one never fires
  assign svc_irq = svc_cond && !svc_mask_r && !(wr_ecr && i_req.wdata[BIT_SVC_MASK]);
  // dma requests need enable and a clear mask
  assign o_dma_req = dma_en_r && !svc_mask_r && fifo_modes &&
                     (o_eff_direction ? out_valid : in_ready);
  // fault edge tracking
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_d_r <= 1'b1;
    end else begin
      fault_d_r <= i_peripheral_fault_n;
    end
  end
  assign fault_ecp = (mode == MODE_ECP);
  // falling edge while enabled, or enabling while the fault is already low
  assign fault_irq = fault_ecp && (
                     (!fault_dis_r && fault_d_r && !i_peripheral_fault_n) ||
                     (wr_ecr && fault_dis_r && !i_req.wdata[BIT_FAULT_DIS] && !i_peripheral_fault_n));
  // low pulse of fixed length, then the line is released for sharing
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_cnt_r <= 8'h00;
    end else if (svc_irq || fault_irq) begin
      irq_cnt_r <= 8'(IRQ_PULSE_CYC);
    end else if (irq_cnt_r != 8'h00) begin
      irq_cnt_r <= irq_cnt_r - 8'h01;
    end
  end
  assign o_irq_out = 1'b0;
  assign o_irq_oe = (irq_cnt_r != 8'h00);
  // remember the last byte read so an underrun in test mode rereads it
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_rd_r <= 8'h00;
    end else if (fifo_rd_host && out_valid) begin
      last_rd_r <= head;
    end
  end
  // read data; capability registers replace the fifo in configuration mode
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_req.rd) begin
      if (i_req.addr == OFS_ECR) begin
        o_rdata <= {mode_r, fault_dis_r, dma_en_r, svc_mask_r, !in_ready, !out_valid};
      end else if (mode == MODE_CFG && i_req.addr == OFS_FIFO) begin
        o_rdata <= CAPA_READ_VAL;
      end else if (mode == MODE_CFG && i_req.addr == OFS_CAPB) begin
        o_rdata <= {CAPB_READ_VAL[7], o_irq_oe, CAPB_READ_VAL[5:0]};
      end else if (fifo_rd_host) begin
        o_rdata <= out_valid ? head : last_rd_r;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule : ecp_extended_control
`default_nettype wire

// ### sim/ecr_chk.sv
// checker for the extended control register block, bound to its ports.
// assumes software alone changes the mode and dma enable fields.
`timescale 1ns/100ps
`default_nettype none
module ecr_chk
  import ecr_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_reset_n, // async reset, active low
  input wire ecr_pkg::host_req_s i_req, // host request
  input wire logic [7:0] o_rdata, // read data
  input wire logic i_direction, // direction bit
  input wire logic i_epp_option_config, // epp option
  input wire logic i_dma_tc, // terminal count
  input wire logic i_peripheral_fault_n, // fault input, active low
  input wire logic o_compat_xfer, // compat engine enable
  input wire logic o_ecp_xfer, // ecp engine enable
  input wire logic o_epp_enable, // epp enable
  input wire ecr_pkg::drive_s o_drive, // driver setup
  input wire logic o_data_readback_pins, // pin readback
  input wire logic o_eff_direction, // effective direction
  input wire logic o_dma_req, // dma request
  input wire logic o_irq_out, // irq level
  input wire logic o_irq_oe // irq enable
);
  logic [2:0] mode_r; // shadow of the mode field
  logic dma_r; // shadow of dma enable, hardware never writes it
  int unsigned pulse_r; // cycles the irq line has been driven
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // shadows follow host writes of the control register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_r <= 3'h0;
      dma_r <= 1'b0;
    end else if (i_req.wr && i_req.addr == OFS_ECR) begin
      mode_r <= i_req.wdata[7:5];
      dma_r <= i_req.wdata[3];
    end
  end
  // pulse width counter, cleared while the line is released
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) pulse_r <= 0;
    else pulse_r <= o_irq_oe ? pulse_r + 1 : 0;
  end
  AST_MODE_RD: assert property (i_req.rd && i_req.addr == OFS_ECR |=>
    o_rdata[7:5] == mode_r && o_rdata[3] == dma_r) else $error("ecr read mismatch");
  AST_DRIVE: assert property (o_drive.push_pull == (mode_r != 3'h0)) else $error("driver kind wrong");
  AST_DIR: assert property (o_eff_direction == (i_direction && mode_r != 3'h0 && mode_r != 3'h2))
    else $error("direction not forced");
  AST_RDBACK: assert property (o_data_readback_pins == (mode_r != 3'h0)) else $error("readback wrong");
  AST_EPP: assert property (o_epp_enable == (mode_r == 3'h4 && i_epp_option_config))
    else $error("epp enable wrong");
  AST_XFER: assert property (!(mode_r inside {3'h2, 3'h3}) |-> !o_compat_xfer && !o_ecp_xfer)
    else $error("transfer outside fifo modes");
  AST_DMA: assert property (!dma_r |-> !o_dma_req) else $error("dma while disabled");
  AST_IRQ_LOW: assert property (o_irq_oe |-> !o_irq_out) else $error("irq not low");
  AST_PULSE: assert property ($fell(o_irq_oe) |-> pulse_r >= IRQ_PULSE_CYC) else $error("irq pulse short");
  AST_CAPA: assert property (i_req.rd && i_req.addr == OFS_FIFO && mode_r == 3'h7 |=>
    o_rdata == CAPA_READ_VAL) else $error("capability a wrong");
  // with the fault line high and no terminal count, a mask write of one leaves nothing to fire on
  AST_W1: assert property (i_req.wr && i_req.addr == OFS_ECR && i_req.wdata[2] &&
    !i_dma_tc && i_peripheral_fault_n |=> !$rose(o_irq_oe)) else $error("irq on mask write");
  // data drivers ignore direction in standard mode, follow it in bidirectional mode
  AST_DATA_OE: assert property ((mode_r == 3'h0 |-> o_drive.data_oe) and
    (mode_r == 3'h1 |-> o_drive.data_oe == !i_direction)) else $error("data drive wrong");
endmodule : ecr_chk
bind ecp_extended_control ecr_chk u_chk (.i_clk, .i_reset_n, .i_req, .o_rdata, .i_direction,
  .i_epp_option_config, .i_dma_tc, .i_peripheral_fault_n, .o_compat_xfer, .o_ecp_xfer, .o_epp_enable, .o_drive,
  .o_data_readback_pins, .o_eff_direction, .o_dma_req, .o_irq_out, .o_irq_oe);
`default_nettype wire

// ### sim/peer_model.sv
// handshake engine and peripheral stand-in on the fifo's far side.
// assumes the engine runs only while the block enables a transfer mode.
`timescale 1ns/100ps
`default_nettype none
module peer_model (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_run, // an engine is enabled
  input wire logic i_src_en, // offer received bytes
  input wire logic [7:0] i_wdata, // transmit head
  input wire logic i_wvalid, // transmit byte present
  output logic o_wready, // stalls every other cycle
  input wire logic i_rready, // fifo takes a byte
  output logic [7:0] o_rdata, // received byte
  output logic o_rvalid // received byte valid
);
  logic [7:0] got [0:15]; // bytes taken off the fifo
  int n_got; // count taken
  int n_src; // count offered and accepted
  // sink: ready toggles so the fifo sees a slow peripheral
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wready <= 1'b0;
      n_got <= 0;
      n_src <= 0;
    end else begin
      o_wready <= !o_wready && i_run;
      if (o_wready && i_wvalid) begin
        got[n_got] <= i_wdata;
        n_got <= n_got + 1;
      end
      if (o_rvalid && i_rready) n_src <= n_src + 1;
    end
  end
  // eight bytes in all after reset, not per run; data is inverted while not valid
  assign o_rvalid = i_src_en && n_src < 8;
  assign o_rdata = o_rvalid ? 8'(8'hA0 + n_src) : ~8'(8'hA0 + n_src);
endmodule : peer_model
`default_nettype wire

// ### sim/testbench.sv
// testbench for the extended control register block with its fifo.
// assumes host strobes driven at the falling edge, one cycle wide.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module testbench;
  import ecr_pkg::*;
  logic clk, rst_n, dir, epp, fault_n, dma_ack, dma_tc, src_en, prv, prr, pwv, pwr, compat, ecp;
  logic eppen, rbp, edir, dreq, iout, ioe;
  logic [7:0] rdata, dma_wdata, prd, pwd;
  host_req_s req;
  drive_s drv;
  int errors, samples_checked, cyc, wid, n_pulse, run;
  ecp_extended_control u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_req(req), .o_rdata(rdata),
    .i_direction(dir), .i_epp_option_config(epp), .i_peripheral_fault_n(fault_n), .i_dma_ack(dma_ack),
    .i_dma_tc(dma_tc), .i_dma_wdata(dma_wdata), .i_port_rdata(prd), .i_port_rvalid(prv),
    .o_port_rready(prr), .o_port_wdata(pwd), .o_port_wvalid(pwv), .i_port_wready(pwr),
    .o_compat_xfer(compat), .o_ecp_xfer(ecp), .o_epp_enable(eppen), .o_drive(drv),
    .o_data_readback_pins(rbp), .o_eff_direction(edir), .o_dma_req(dreq), .o_irq_out(iout), .o_irq_oe(ioe));
  peer_model u_peer (.i_clk(clk), .i_rst_n(rst_n), .i_run(compat | ecp), .i_src_en(src_en), .i_wdata(pwd),
    .i_wvalid(pwv), .o_wready(pwr), .i_rready(prr), .o_rdata(prd), .o_rvalid(prv));
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      finish_test();
    end
  end
  // pulse monitor at the falling edge: a pulse already running when a test starts looking is still measured whole
  always @(negedge clk) begin
    if (ioe === 1'b1) begin
      run++;
    end else if (run != 0) begin
      n_pulse++;
      wid = run;
      run = 0;
    end
  end
  task finish_test;
    $display("checked %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task tend(input string s);
    $display("test %s done", s);
  endtask : tend
  // host write: strobe one cycle
  task wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr
  // host read: data is registered, so it is settled a cycle later
  task rd(input logic [10:0] a, input logic [7:0] e);
    @(negedge clk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk);
    req.rd = 1'b0;
    `CHK(rdata, e)
  endtask : rd
  // watch a fixed window; the monitor counts finished pulses and keeps the last width
  task irq(input logic e);
    int n0;
    n0 = n_pulse;
    repeat (40) @(negedge clk);
    `CHK(n_pulse - n0, int'(e))
    if (e) `CHK(wid, IRQ_PULSE_CYC)
  endtask : irq
  initial begin
    req = '0; rst_n = 0; dir = 1; epp = 1; fault_n = 1; dma_ack = 0; dma_tc = 0; dma_wdata = 8'h00;
    src_en = 0; errors = 0; samples_checked = 0; cyc = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(OFS_ECR, 8'h05);
    tend("reset");
    for (int m = 0; m < 8; m++) begin
      wr(OFS_ECR, {m[2:0], 5'h04});
      rd(OFS_ECR, {m[2:0], 5'h05});
      `CHK(drv.push_pull, (m != 0))
      `CHK(edir, (m != 0 && m != 2))
      `CHK(eppen, (m == 4))
      wr(OFS_ECR, 8'h04);
    end
    tend("modes");
    wr(OFS_ECR, 8'hC4);
    for (int i = 0; i < 17; i++) wr(OFS_FIFO, 8'(i * 17));
    rd(OFS_ECR, 8'hC6);
    for (int i = 0; i < 16; i++) rd(OFS_FIFO, 8'(i * 17));
    rd(OFS_ECR, 8'hC5);
    rd(OFS_FIFO, 8'hFF);
    `CHK(u_peer.n_got, 0)
    wr(OFS_ECR, 8'h04);
    wr(OFS_ECR, 8'hE4);
    rd(OFS_FIFO, CAPA_READ_VAL);
    rd(OFS_CAPB, CAPB_READ_VAL);
    wr(OFS_ECR, 8'h04);
    tend("fifo");
    dir = 1'b0;
    wr(OFS_ECR, 8'h40);
    irq(1'b1);
    rd(OFS_ECR, 8'h45);
    wr(OFS_ECR, 8'h44);
    irq(1'b0);
    for (int i = 0; i < 3; i++) wr(OFS_FIFO, 8'(8'h30 + i));
    repeat (10) @(negedge clk);
    `CHK(u_peer.n_got, 3)
    for (int i = 0; i < 3; i++) `CHK(u_peer.got[i], 8'(8'h30 + i))
    wr(OFS_ECR, 8'h04);
    tend("forward");
    wr(OFS_ECR, 8'h24);
    dir = 1'b1;
    wr(OFS_ECR, 8'h60);
    src_en = 1'b1;
    irq(1'b1);
    for (int i = 0; i < 8; i++) rd(OFS_FIFO, 8'(8'hA0 + i));
    rd(OFS_ECR, 8'h65);
    src_en = 1'b0;
    tend("reverse");
    wr(OFS_ECR, 8'h74);
    fault_n = 1'b0;
    irq(1'b0);
    wr(OFS_ECR, 8'h64);
    irq(1'b1);
    fault_n = 1'b1;
    repeat (3) @(negedge clk);
    fault_n = 1'b0;
    irq(1'b1);
    fault_n = 1'b1;
    wr(OFS_ECR, 8'h24);
    fault_n = 1'b0;
    irq(1'b0);
    fault_n = 1'b1;
    tend("fault");
    dir = 1'b0;
    wr(OFS_ECR, 8'h6C);
    `CHK(dreq, 1'b0)
    wr(OFS_ECR, 8'h68);
    `CHK(dreq, 1'b1)
    dma_wdata = 8'h77;
    dma_ack = 1'b1;
    @(negedge clk);
    dma_ack = 1'b0;
    @(negedge clk);
    dma_tc = 1'b1;
    @(negedge clk);
    dma_tc = 1'b0;
    irq(1'b1);
    `CHK(dreq, 1'b0)
    rd(OFS_ECR, 8'h6D);
    wr(11'h000, 8'h5A);
    wr(OFS_FIFO, 8'hA5);
    repeat (10) @(negedge clk);
    `CHK(u_peer.n_got, 6)
    `CHK(u_peer.got[3], 8'h77)
    `CHK(u_peer.got[4], 8'h5A)
    `CHK(u_peer.got[5], 8'hA5)
    tend("dma");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
